//--- src/tally_consts.vh
// constants for the 10-bit up/down tally counter with compare and pwm
// assumes inclusion by the counter module only
`ifndef TALLY_CONSTS_VH
`define TALLY_CONSTS_VH
`define ADDR_W 3
`define A_CLKDIR 3'h0
`define A_RUNMODE 3'h1
`define A_VAL_LO 3'h2
`define A_VAL_MID 3'h3
`define A_VAL_HI 3'h4
`define A_SYSCTL 3'h5
`define A_PRESC 3'h6
`define B_DIR 3
`define B_START 3
`define B_EVENT 2
`define B_CMPEN 1
`define B_LOAD 0
`define B_CMPW 1
`define B_PWMRT 0
`define ZERO10 10'h000
`define ONES10 10'h3ff
`define LEN_10 2'h0
`define LEN_8 2'h1
`define LEN_6 2'h2
`define LEN_4 2'h3
`define SRC_PIN_A 3'h0
`define SRC_T19 3'h1
`define SRC_T16 3'h2
`define SRC_T13 3'h3
`define SRC_T10 3'h4
`define SRC_T4 3'h5
`define SRC_T1 3'h6
`define SRC_PIN_B 3'h7
`endif

//--- src/tally_counter.v
// 10-bit cyclic up/down tally counter with compare, pwm and event counting
// assumes a nibble register port, prescaler taps and port pins sync to clock
`include "tally_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module tally_counter #(
    parameter CW = 10
) (
    input wire clock,                      // system clock
    input wire resetn,                     // async reset, low active
    input wire clk_en,                     // freezes all state when low
    input wire [`ADDR_W-1:0] reg_addr,     // register index
    input wire [3:0] reg_wdata,            // write nibble
    input wire reg_wr,                     // write strobe
    input wire reg_rd,                     // read strobe
    output reg [3:0] reg_rdata,            // read nibble, cycle after strobe
    input wire [5:0] prescaler_taps,       // taps 19,16,13,10,4,1
    input wire event_input_a,              // port pin 0
    input wire event_input_b,              // port pin 3
    input wire [1:0] pin_edge_invert,      // invert per pin, [0]=a [1]=b
    input wire [1:0] pin_debounce_bypass,  // 1 = pin undebounced
    input wire port_b3_data,               // normal port data bit 3
    output reg pulse_output_pin,           // port b bit 3 output
    output reg zero_rollover_irq,          // rollover pulse
    output reg compare_match_irq           // compare match pulse
);
    // ----------------------------------------------------------
    // registers
    // ----------------------------------------------------------
    reg [3:0] clkdir_ff;
    reg [2:0] runmode_ff;   // start, event, cmp enable
    reg [1:0] sysctl_ff;
    reg pwm_route_ff;
    reg [CW-1:0] preset_ff;
    reg [1:0] len_ff;
    reg [CW-1:0] count_ff;
    reg [5:0] upper_shadow_value;
    reg pwm_ff;
    reg load_ff;
    reg [2:0] src_sync_ff;
    reg half_ff;
    reg neg_seen_ff;
    reg running_ff;

    wire dir_up = clkdir_ff[`B_DIR];
    wire [2:0] tally_clock_source = clkdir_ff[2:0];
    wire start = runmode_ff[`B_START-1];
    wire event_tally_mode = runmode_ff[`B_EVENT-1];
    wire comparator_enable = runmode_ff[`B_CMPEN-1];
    wire compare_width_select = sysctl_ff[`B_CMPW];

    // ----------------------------------------------------------
    // clock source selection
    // ----------------------------------------------------------
    reg raw_src;
    reg src_undeb;
    always @* begin
        src_undeb = 1'b0;
        case (tally_clock_source)
            `SRC_PIN_A: begin
                raw_src = event_input_a ^ pin_edge_invert[0];
                src_undeb = pin_debounce_bypass[0];
            end
            `SRC_T19: raw_src = prescaler_taps[5];
            `SRC_T16: raw_src = prescaler_taps[4];
            `SRC_T13: raw_src = prescaler_taps[3];
            `SRC_T10: raw_src = prescaler_taps[2];
            `SRC_T4: raw_src = prescaler_taps[1];
            `SRC_T1: raw_src = prescaler_taps[0];
            `SRC_PIN_B: begin
                raw_src = event_input_b ^ pin_edge_invert[1];
                src_undeb = pin_debounce_bypass[1];
            end
            default: raw_src = 1'b0;
        endcase
    end

    // length mask for limited counting
    function [CW-1:0] len_mask;
        input [1:0] sel;
        begin
            case (sel)
                `LEN_10: len_mask = `ONES10;
                `LEN_8: len_mask = 10'h0ff;
                `LEN_6: len_mask = 10'h03f;
                `LEN_4: len_mask = 10'h00f;
                default: len_mask = `ONES10;
            endcase
        end
    endfunction

    wire [CW-1:0] mask = len_mask(len_ff);
    // ----------------------------------------------------------
    // edge detection after two-stage synchroniser
    // ----------------------------------------------------------
    wire sync_rise = src_sync_ff[1] & ~src_sync_ff[2];
    wire sync_fall = ~src_sync_ff[1] & src_sync_ff[2];
    // undebounced pins step only on every second rising edge
    wire step_edge = src_undeb ? (sync_rise & half_ff) : sync_rise;
    wire can_run = start & (event_tally_mode | neg_seen_ff);
    wire step = step_edge & can_run & running_ff;

    wire [CW-1:0] next_cnt = dir_up ? count_ff + 10'h001 : count_ff - 10'h001;
    wire roll_hit = dir_up ? ((next_cnt & mask) == mask)
                           : ((next_cnt & mask) == `ZERO10);
    wire [CW-1:0] cmp_mask = compare_width_select ? `ONES10 : mask;
    wire irq_match = comparator_enable &
                     ((next_cnt & cmp_mask) == (preset_ff & cmp_mask));
    wire pwm_match = comparator_enable &
                     ((next_cnt & mask) == (preset_ff & mask));

    // ----------------------------------------------------------
    // register port and counter core
    // ----------------------------------------------------------
    wire wr_clkdir = reg_wr & (reg_addr == `A_CLKDIR);
    wire wr_run = reg_wr & (reg_addr == `A_RUNMODE);
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            clkdir_ff <= 4'h0;
            runmode_ff <= 3'h0;
            sysctl_ff <= 2'h0;
            pwm_route_ff <= 1'b0;
            preset_ff <= `ZERO10;
            len_ff <= `LEN_10;
            count_ff <= `ZERO10;
            upper_shadow_value <= 6'h00;
            pwm_ff <= 1'b0;
            load_ff <= 1'b0;
            src_sync_ff <= 3'h0;
            half_ff <= 1'b0;
            neg_seen_ff <= 1'b0;
            running_ff <= 1'b0;
            reg_rdata <= 4'h0;
            pulse_output_pin <= 1'b0;
            zero_rollover_irq <= 1'b0;
            compare_match_irq <= 1'b0;
        end else if (clk_en) begin
            src_sync_ff <= {src_sync_ff[1:0], raw_src};
            zero_rollover_irq <= 1'b0;
            compare_match_irq <= 1'b0;
            load_ff <= 1'b0;
            if (sync_rise)
                half_ff <= ~half_ff;
            if (!start) begin
                neg_seen_ff <= 1'b0;
                half_ff <= 1'b0;
                running_ff <= 1'b1;
            end else if (sync_fall)
                neg_seen_ff <= 1'b1;
            // counting
            if (step) begin
                count_ff <= next_cnt;
                if (roll_hit) begin
                    zero_rollover_irq <= 1'b1;
                    // roll-over drives the active level: high counting up, low counting down
                    if (comparator_enable)
                        pwm_ff <= dir_up;
                end
                if (pwm_match)
                    pwm_ff <= dir_up ? 1'b0 : 1'b1;
                if (irq_match) begin
                    compare_match_irq <= 1'b1;
                    if (pwm_route_ff) begin
                        running_ff <= 1'b0;
                        runmode_ff[`B_START-1] <= 1'b0;
                    end
                end
            end
            // register writes
            if (wr_clkdir) begin
                clkdir_ff <= reg_wdata;
                if (reg_wdata[`B_DIR] != dir_up) begin
                    count_ff <= ~count_ff;
                    pwm_ff <= reg_wdata[`B_DIR] ? 1'b0 : 1'b1;
                end
            end
            if (wr_run) begin
                runmode_ff <= reg_wdata[3:1];
                if (reg_wdata[`B_LOAD]) begin
                    load_ff <= 1'b1;
                    count_ff <= preset_ff;
                    pwm_ff <= ~dir_up;
                    runmode_ff[`B_CMPEN-1] <= 1'b0;
                    if (preset_ff == `ZERO10)
                        runmode_ff[`B_START-1] <= 1'b0;
                end
            end
            if (reg_wr & (reg_addr == `A_SYSCTL))
                sysctl_ff <= reg_wdata[1:0];
            if (reg_wr & (reg_addr == `A_PRESC))
                pwm_route_ff <= reg_wdata[`B_PWMRT];
            if (reg_wr & (reg_addr == `A_VAL_LO))
                preset_ff[3:0] <= reg_wdata;
            if (reg_wr & (reg_addr == `A_VAL_MID))
                preset_ff[7:4] <= reg_wdata;
            if (reg_wr & (reg_addr == `A_VAL_HI)) begin
                preset_ff[9:8] <= reg_wdata[1:0];
                len_ff <= reg_wdata[3:2];
            end
            // register reads
            if (reg_rd) begin
                case (reg_addr)
                    `A_CLKDIR: reg_rdata <= clkdir_ff;
                    `A_RUNMODE: reg_rdata <= {runmode_ff, 1'b0};
                    `A_VAL_LO: begin
                        reg_rdata <= count_ff[3:0];
                        upper_shadow_value <= count_ff[9:4];
                    end
                    `A_VAL_MID: reg_rdata <= upper_shadow_value[3:0];
                    `A_VAL_HI: reg_rdata <= {len_ff, upper_shadow_value[5:4]};
                    `A_SYSCTL: reg_rdata <= {2'h0, sysctl_ff};
                    `A_PRESC: reg_rdata <= {3'h0, pwm_route_ff};
                    default: reg_rdata <= 4'h0;
                endcase
            end else
                reg_rdata <= 4'h0;
            // a match on a load/start value never counts: only steps compare
            pulse_output_pin <= pwm_route_ff ? pwm_ff : port_b3_data;
        end
    end
endmodule // tally_counter
`default_nettype wire

//--- tb/tap_pin_model.sv
// far side model: prescaler taps and the two port pins
// assumes one free running system clock
`timescale 1ns/1ps
`default_nettype none
module tap_pin_model (
    input wire logic clock, // system clock
    input wire logic resetn, // async reset, low active
    output wire logic [5:0] prescaler_taps, // divided levels, [0] fastest
    output wire logic event_input_a, // pin 0, slow event stream
    output wire logic event_input_b // pin 3, slower event stream
);
    logic [7:0] div_ff;
    always @(posedge clock or negedge resetn) begin
        if (!resetn)
            div_ff <= 8'h00;
        else
            div_ff <= div_ff + 8'h01;
    end
    assign prescaler_taps = div_ff[7:2];
    // pins toggle slowly so event counting sees clean edges
    assign event_input_a = div_ff[3];
    assign event_input_b = div_ff[4];
endmodule // tap_pin_model
`default_nettype wire

//--- tb/tally_chk.sv
// port checker for the tally counter
// assumes clk_en is held high
`timescale 1ns/1ps
`default_nettype none
module tally_chk (
    input wire logic clock, // system clock
    input wire logic resetn, // async reset
    input wire logic [2:0] reg_addr, // register index
    input wire logic [3:0] reg_wdata, // write nibble
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [3:0] reg_rdata, // read nibble
    input wire logic port_b3_data, // port data
    input wire logic pulse_output_pin, // pin output
    input wire logic zero_rollover_irq, // rollover pulse
    input wire logic compare_match_irq // match pulse
);
    logic [3:0] cd_ff;
    logic ev_ff, cm_ff, rt_ff;
    logic [1:0] live_ff;
    wire wr1 = reg_wr && reg_addr == 3'h1;
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cd_ff <= 4'h0;
            ev_ff <= 1'b0;
            cm_ff <= 1'b0;
            rt_ff <= 1'b0;
            live_ff <= 2'h0;
        end else begin
            if (reg_wr && reg_addr == 3'h0)
                cd_ff <= reg_wdata;
            if (wr1)
                ev_ff <= reg_wdata[2];
            // a load in the same write clears the enable
            if (wr1)
                cm_ff <= reg_wdata[1] & ~reg_wdata[0];
            if (reg_wr && reg_addr == 3'h6)
                rt_ff <= reg_wdata[0];
            if (live_ff != 2'h3)
                live_ff <= live_ff + 2'h1;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    AST_ROLL_PULSE: assert property (zero_rollover_irq |=> !zero_rollover_irq)
        else $error("rollover pulse longer than one cycle");
    AST_CMP_PULSE: assert property (compare_match_irq |=> !compare_match_irq)
        else $error("compare pulse longer than one cycle");
    AST_LOAD_READ: assert property (reg_rd && reg_addr == 3'h1 |=> !reg_rdata[0])
        else $error("load bit read back as one");
    AST_SRC_READ: assert property (reg_rd && reg_addr == 3'h0 |=> reg_rdata == $past(cd_ff))
        else $error("clock and direction register readback wrong");
    AST_EVT_READ: assert property (reg_rd && reg_addr == 3'h1 |=> reg_rdata[2] == $past(ev_ff))
        else $error("event mode bit readback wrong");
    AST_NO_CMP: assert property (!cm_ff && !$past(cm_ff) |-> !compare_match_irq)
        else $error("compare irq with comparator off");
    AST_LOAD_QUIET: assert property (wr1 && reg_wdata[0] |=> !zero_rollover_irq && !compare_match_irq)
        else $error("irq raised by a load");
    AST_PIN_PASS: assert property (live_ff == 2'h3 && !rt_ff && !$past(rt_ff)
        |-> pulse_output_pin == $past(port_b3_data))
        else $error("port bit 3 not passed through");
    COV_CMP: cover property (compare_match_irq);
    COV_ROLL: cover property (zero_rollover_irq);
    COV_PWM: cover property (rt_ff && $rose(pulse_output_pin));
endmodule // tally_chk
bind tally_counter tally_chk u_chk (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .port_b3_data(port_b3_data), .pulse_output_pin(pulse_output_pin),
    .zero_rollover_irq(zero_rollover_irq), .compare_match_irq(compare_match_irq));
`default_nettype wire

//--- tb/tb_top.sv
// self-checking bench for the tally counter
// assumes a 50 MHz clock and the nibble register port
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; \
    $display("[ERR] %0t got %h expected %h", $time, a, b); end end
module tb_top;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [3:0] reg_wdata = 4'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic port_b3_data = 1'b0;
    logic [3:0] reg_rdata, d, x;
    logic [5:0] taps;
    logic ev_a, ev_b, pin, roll_irq, cmp_irq, ok;
    logic [7:0] lfsr = 8'h43;
    logic [9:0] v;
    int n_errors = 0;
    int checked = 0;
    int n, r;
    always #10 clock = ~clock;
    tap_pin_model partner (.clock(clock), .resetn(resetn), .prescaler_taps(taps),
        .event_input_a(ev_a), .event_input_b(ev_b));
    tally_counter DUT (.clock(clock), .resetn(resetn), .clk_en(1'b1), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .prescaler_taps(taps), .event_input_a(ev_a), .event_input_b(ev_b),
        .pin_edge_invert(2'h0), .pin_debounce_bypass(2'h0), .port_b3_data(port_b3_data),
        .pulse_output_pin(pin), .zero_rollover_irq(roll_irq), .compare_match_irq(cmp_irq));
    function automatic [7:0] lfsr_next(input [7:0] s);
        lfsr_next = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // 4-bit length: upper compare bits give the pulse count
    function automatic [5:0] pwm_pulses(input [9:0] cmp);
        pwm_pulses = cmp[9:4];
    endfunction
    always @(posedge clock) begin
        lfsr <= lfsr_next(lfsr);
        port_b3_data <= lfsr[0];
    end
    task automatic wr(input [2:0] a, input [3:0] w);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= w;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input [2:0] a, output [3:0] q);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask
    task automatic wr3(input [9:0] w, input [1:0] len);
        wr(3'h2, w[3:0]);
        wr(3'h3, w[7:4]);
        wr(3'h4, {len, w[9:8]});
    endtask
    task automatic rd3(output [9:0] q);
        logic [3:0] l, m, h;
        rd(3'h2, l);
        rd(3'h3, m);
        rd(3'h4, h);
        q = {h[1:0], m, l};
    endtask
    task automatic wait_irq(input bit cmp, output logic seen, output int rises);
        int c;
        logic last;
        c = 0;
        rises = 0;
        last = pin;
        while ((cmp ? cmp_irq : roll_irq) !== 1'b1 && c < 4000) begin
            @(posedge clock);
            #1;
            if (pin === 1'b1 && last === 1'b0)
                rises++;
            last = pin;
            c++;
        end
        seen = c < 4000;
    endtask
    task tally_and_finish;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #400_000;
        n_errors++;
        tally_and_finish;
    end
    initial begin
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        rd(3'h0, d);
        `CHK(d, 4'h0)
        rd(3'h1, d);
        `CHK(d, 4'h0)
        rd(3'h7, d);
        `CHK(d, 4'h0)
        for (n = 0; n < 6; n++) begin
            x = lfsr[3:0];
            wr(3'h0, x);
            rd(3'h0, d);
            `CHK(d, x)
        end
        wr(3'h1, 4'h0);
        wr(3'h0, 4'he);
        wr3(10'h3fc, 2'h0);
        wr(3'h1, 4'h1);
        rd(3'h1, d);
        `CHK(d[0], 1'b0)
        rd3(v);
        `CHK(v, 10'h3fc)
        wr(3'h1, 4'h8);
        wait_irq(1'b0, ok, r);
        `CHK(ok, 1'b1)
        // tap steps every 8 cycles, so the stop lands before the next step
        wr(3'h1, 4'h0);
        repeat (10) @(posedge clock);
        rd3(v);
        `CHK(v, 10'h3ff)
        wr(3'h0, 4'h6);
        rd3(v);
        `CHK(v, ~10'h3ff)
        wr3(10'h000, 2'h0);
        wr(3'h1, 4'h9);
        rd(3'h1, d);
        `CHK(d[3], 1'b0)
        wr(3'h0, 4'he);
        wr(3'h1, 4'h1);
        wr3(10'h052, 2'h3);
        wr(3'h5, 4'h2);
        wr(3'h6, 4'h1);
        repeat (2) @(posedge clock);
        #1;
        `CHK(pin, 1'b0)
        wr(3'h1, 4'ha);
        wait_irq(1'b1, ok, r);
        `CHK(ok, 1'b1)
        `CHK(r[5:0], pwm_pulses(10'h052))
        rd(3'h1, d);
        `CHK(d[3], 1'b0)
        wr(3'h6, 4'h0);
        // event mode on pin a: about one step per 16 cycles
        wr(3'h0, 4'h8);
        wr3(10'h100, 2'h0);
        wr(3'h1, 4'h1);
        wr(3'h1, 4'hc);
        repeat (64) @(posedge clock);
        wr(3'h1, 4'h0);
        rd3(v);
        `CHK(v >= 10'h103 && v <= 10'h105, 1'b1)
        repeat (4) @(posedge clock);
        tally_and_finish;
    end
endmodule // tb_top
`default_nettype wire
